// ==== verification/fetch_model.sv ====
// Fetch pipeline model: serves queued extension words to the decoder.
// Assumes the bench loads the words of a decode before it starts.
`default_nettype none
module fetch_model
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [15:0] load_word,
   input wire logic slow,
   input wire logic ext_req,
   output logic ext_valid,
   output logic [15:0] ext_word,
   output logic [7:0] taken
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] q[$];
   ////////////////////////////////////////
   // An idle word line shows the inverse of its last value.
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         q.delete();
         ext_valid <= 1'h0;
         ext_word <= 16'h0;
         taken <= 8'h00;
      end
      else
      begin
         if (load)
            q.push_back(load_word);
         if (ext_req && ext_valid)
         begin
            void'(q.pop_front());
            taken <= taken + 8'h01;
         end
         if (q.size() > 0 && !(slow && $urandom_range(1, 0) == 1))
         begin
            ext_valid <= 1'h1;
            ext_word <= q[0];
         end
         else
         begin
            ext_valid <= 1'h0;
            ext_word <= ~ext_word;
         end
      end
   end
endmodule // fetch_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench of the effective address unit against a reference model.
// Assumes the fetch model and the design files are compiled first.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic start = 1'h0, load = 1'h0, slow = 1'h0, err;
   logic pready, pslverr, ext_req, ext_valid, done, ea_is_reg, ea_is_imm;
   logic program_space, reg_update, illegal_trap;
   logic [11:0] paddr = 12'h000;
   logic [2:0] ea_mode = 3'h0, ea_reg = 3'h0;
   logic [1:0] op_size = 2'h0;
   logic [31:0] pwdata = 32'h0, ext_pc = 32'h0, prdata, ea_addr, imm_data, rd, last_ea, v;
   logic [7:0][31:0] data_regs = '0, addr_regs = '0;
   logic [15:0] ext_word, load_word = 16'h0;
   logic [3:0] ea_reg_sel;
   logic [7:0] taken;
   int num_errors = 0, n_tests = 0, n_done = 0, i, j;
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (done === 1'h1)
         n_done++;
   effective_address_generator dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .start(start), .ea_mode(ea_mode), .ea_reg(ea_reg),
      .op_size(op_size), .ext_pc(ext_pc), .data_regs(data_regs), .addr_regs(addr_regs),
      .ext_req(ext_req), .ext_valid(ext_valid), .ext_word(ext_word), .done(done),
      .ea_addr(ea_addr), .ea_is_reg(ea_is_reg), .ea_is_imm(ea_is_imm), .imm_data(imm_data),
      .ea_reg_sel(ea_reg_sel), .program_space(program_space), .reg_update(reg_update),
      .illegal_trap(illegal_trap));
   fetch_model fm (.sys_clk(sys_clk), .rst(rst), .load(load), .load_word(load_word),
      .slow(slow), .ext_req(ext_req), .ext_valid(ext_valid), .ext_word(ext_word),
      .taken(taken));
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      k = 0;
      do begin @(posedge sys_clk); k++; end while (pready !== 1'h1 && k < 20);
      chk("pready", pready, 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   function automatic logic [31:0] sx(input logic [15:0] x);
      return {{16{x[15]}}, x};
   endfunction
   function automatic logic [31:0] xi(input logic [15:0] w);
      logic [31:0] r;
      r = w[15] ? addr_regs[w[14:12]] : data_regs[w[14:12]];
      if (!w[11])
         r = sx(r[15:0]);
      return r << w[10:9];
   endfunction
   function automatic logic [31:0] ref_ea(input logic [2:0] m, r, input logic [1:0] sz,
      input logic [15:0] w0, w1, w2);
      logic [31:0] b;
      b = (m == 3'h6) ? addr_regs[r] : ext_pc;
      if (m == 3'h4)
         return addr_regs[r] - (32'h1 << sz);
      if (m == 3'h5)
         return addr_regs[r] + sx(w0);
      if (m < 3'h4)
         return addr_regs[r];
      if (m == 3'h6 || r == 3'h3)
      begin
         if (!w0[8])
            return b + sx({{8{w0[7]}}, w0[7:0]}) + xi(w0);
         return (w0[7] ? 32'h0 : b) + (w0[6] ? 32'h0 : xi(w0)) + (w0[5:4] == 2'h3 ?
            {w1, w2} : w0[5:4] == 2'h2 ? sx(w1) : 32'h0);
      end
      return r == 3'h0 ? sx(w0) : r == 3'h1 ? {w0, w1} : r == 3'h2 ? ext_pc + sx(w0) : ext_pc;
   endfunction
   function automatic int nwords(input logic [2:0] m, r, input logic [1:0] sz,
      input logic [15:0] w0);
      if (m == 3'h5 || (m == 3'h7 && (r == 3'h0 || r == 3'h2)))
         return 1;
      if (m == 3'h6 || (m == 3'h7 && r == 3'h3))
         return (w0[8] && w0[5]) ? int'(w0[5:4]) : 1;
      if (m == 3'h7 && (r == 3'h1 || (r == 3'h4 && sz == 2'h2)))
         return 2;
      return (m == 3'h7 && r == 3'h4) ? 1 : 0;
   endfunction
   task automatic dec(input logic [2:0] m, r, input logic [1:0] sz,
      input logic [15:0] w0, w1, w2, input logic trap);
      int n, k;
      logic s;
      logic [7:0] t0;
      logic [15:0] w[3];
      w = '{w0, w1, w2};
      n = nwords(m, r, sz, w0);
      s = 1'($urandom_range(1, 0));
      @(posedge sys_clk);
      for (k = 0; k < 8; k++)
      begin
         data_regs[k] <= $urandom();
         addr_regs[k] <= $urandom();
      end
      ext_pc <= $urandom();
      slow <= s;
      for (k = 0; k < n; k++)
      begin
         load <= 1'h1;
         load_word <= w[k];
         @(posedge sys_clk);
      end
      load <= 1'h0;
      ea_mode <= m;
      ea_reg <= r;
      op_size <= sz;
      start <= 1'h1;
      t0 = taken;
      @(posedge sys_clk);
      start <= 1'h0;
      k = 0;
      do begin @(posedge sys_clk); k++; end
         while (done !== 1'h1 && illegal_trap !== 1'h1 && k < 40);
      chk("finish", done | illegal_trap, 1'h1);
      chk("trap", illegal_trap, trap);
      chk("words", taken - t0, n);
      if (!trap)
      begin
         if (!s)
            chk("cycles", k, n + 2);
         if (m < 3'h2)
            chk("regsel", {ea_is_reg, ea_reg_sel}, {1'h1, m[0], r});
         else
            chk("ea", ea_addr, ref_ea(m, r, sz, w0, w1, w2));
         chk("flags", {ea_is_reg, ea_is_imm, program_space, reg_update}, {m < 3'h2,
            m == 3'h7 && r == 3'h4, m == 3'h7 && r > 3'h1, m == 3'h3 || m == 3'h4});
         if (m == 3'h7 && r == 3'h4)
            chk("imm", imm_data, sz == 2'h0 ? {24'h0, w0[7:0]} : sz == 2'h1 ?
               {16'h0, w0} : {w0, w1});
         if (m > 3'h1)
            last_ea = ea_addr;
      end
   endtask
   ////////////////////////////////////////
   initial
   begin
      #2000000;
      num_errors++;
      final_report;
   end
   initial
   begin
      void'($urandom(32'h85079F16));
      repeat (4) @(posedge sys_clk);
      rst <= 1'h0;
      apb(1'h0, 12'h000, 32'h0);
      chk("ctrl", rd, 32'h1);
      apb(1'h0, 12'h00C, 32'h0);
      chk("slverr", err, 1'h1);
      chk("unmapped", rd, 32'h0);
      for (i = 0; i < 18; i++)
         dec(3'(i / 3), 3'($urandom), 2'(i % 3), 16'($urandom), 16'h0, 16'h0, 1'h0);
      $display("register modes done");
      for (i = 0; i < 32; i++)
      begin
         v = $urandom();
         dec(i[4] ? 3'h7 : 3'h6, i[4] ? 3'h3 : v[18:16], 2'h2,
            {i[0], v[14:12], i[1], i[3:2], 1'h0, v[7:0]}, 16'h0, 16'h0, 1'h0);
      end
      $display("brief index done");
      for (i = 0; i < 24; i++)
      begin
         v = $urandom();
         dec(i > 11 ? 3'h7 : 3'h6, i > 11 ? 3'h3 : v[18:16], 2'h2, {v[15:9], 1'h1, i[0],
            i[1], 2'(i / 4 % 3 + 1), 4'h0}, v[31:16], 16'(~v), 1'h0);
      end
      $display("full index done");
      for (i = 0; i < 12; i++)
         dec(3'h7, i % 4 == 3 ? 3'h4 : 3'(i % 4), 2'(i / 4), 16'($urandom),
            16'($urandom), 16'h0, 1'h0);
      apb(1'h1, 12'h008, 32'h0);
      apb(1'h0, 12'h008, 32'h0);
      chk("last_ea", rd, last_ea);
      $display("special modes done");
      for (i = 5; i < 8; i++)
         dec(3'h7, 3'(i), 2'h2, 16'h0, 16'h0, 16'h0, 1'h1);
      dec(3'h6, 3'h1, 2'h2, 16'h0100, 16'h0, 16'h0, 1'h1);
      dec(3'h6, 3'h2, 2'h2, 16'h0151, 16'h0, 16'h0, 1'h1);
      apb(1'h0, 12'h004, 32'h0);
      chk("status", rd, 32'h2);
      apb(1'h1, 12'h004, 32'h2);
      apb(1'h0, 12'h004, 32'h0);
      chk("status_clr", rd, 32'h0);
      apb(1'h1, 12'h000, 32'h0);
      i = n_done;
      @(posedge sys_clk);
      start <= 1'h1;
      @(posedge sys_clk);
      start <= 1'h0;
      repeat (6) @(posedge sys_clk);
      chk("disabled", n_done - i, 0);
      apb(1'h1, 12'h000, 32'h1);
      dec(3'h2, 3'h5, 2'h0, 16'h0, 16'h0, 16'h0, 1'h0);
      $display("traps and control done");
      final_report;
   end
endmodule // testbench
`default_nettype wire

// ==== verilog/ea_pkg.sv ====
// Types shared by the effective address unit.
// Assumes nothing of its surroundings.
`default_nettype none
package ea_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_BD, ST_CALC} state_t;
endpackage
`default_nettype wire

// ==== verilog/ea_regs.svh ====
// Constants of the effective address unit: mode codes, extension word fields,
// size codes and the register map of its APB slave.
// Assumes it is included by bare name by the package user files.
`ifndef EA_REGS_SVH
`define EA_REGS_SVH
`define MODE_DREG 3'h0
`define MODE_AREG 3'h1
`define MODE_IND 3'h2
`define MODE_POSTINC 3'h3
`define MODE_PREDEC 3'h4
`define MODE_DISP16 3'h5
`define MODE_INDEX 3'h6
`define MODE_SPECIAL 3'h7
`define SUB_ABS_SHORT 3'h0
`define SUB_ABS_LONG 3'h1
`define SUB_PC_DISP 3'h2
`define SUB_PC_INDEX 3'h3
`define SUB_IMMEDIATE 3'h4
`define EXT_DA_BIT 15
`define EXT_REG_MSB 14
`define EXT_REG_LSB 12
`define EXT_WL_BIT 11
`define EXT_SCALE_MSB 10
`define EXT_SCALE_LSB 9
`define EXT_FULL_BIT 8
`define EXT_BS_BIT 7
`define EXT_IS_BIT 6
`define EXT_BDSZ_MSB 5
`define EXT_BDSZ_LSB 4
`define EXT_IIS_MSB 2
`define EXT_IIS_LSB 0
`define BDSZ_RESERVED 2'h0
`define BDSZ_NULL 2'h1
`define BDSZ_WORD 2'h2
`define BDSZ_LONG 2'h3
`define IIS_NONE 3'h0
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_LAST_EA 12'h008
`define CTRL_RESET 32'h0000_0001
`define CTRL_EN_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_ILL_BIT 1
`endif

// ==== verilog/effective_address_generator.sv ====
// Effective address decode and calculation unit with an APB control slave.
// Assumes the fetch pipeline answers ext_req with ext_valid and one word per
// accepted cycle, and that the register file contents are stable during a decode.
`include "ea_regs.svh"
`default_nettype none

// Overview of operation
// - Modes 000 to 101 map to register direct, indirect and displacement forms.
// - Mode 110 is address register indexed, brief or full by the format bit.
// - Mode 111 uses the register field as submode 000 to 100.
// - Base suppress bit removes the base register from the sum.
// - Index is the whole register or its sign-extended low word.
// - Index is shifted left by zero to three positions before adding.
// - Full format accepts displacements of up to 32 bits.
// - Index suppress bit removes the index from the sum.
// - Scaling adds no cycle compared with an unscaled index.
// - Index type bit picks data register on 0, address register on 1.
// - Index width bit picks sign-extended word on 0, long on 1.
// - Displacement size 00 reserved, 01 null, 10 word, 11 long.
// - Memory indirect request traps; indirect select must be 000.
// - PC relative base is ext_pc captured at start; program space reads.
module effective_address_generator
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic start,
   input wire logic [2:0] ea_mode,
   input wire logic [2:0] ea_reg,
   input wire logic [1:0] op_size,
   input wire logic [31:0] ext_pc,
   input wire logic [7:0][31:0] data_regs,
   input wire logic [7:0][31:0] addr_regs,
   output logic ext_req,
   input wire logic ext_valid,
   input wire logic [15:0] ext_word,
   output logic done,
   output logic [31:0] ea_addr,
   output logic ea_is_reg,
   output logic ea_is_imm,
   output logic [31:0] imm_data,
   output logic [3:0] ea_reg_sel,
   output logic program_space,
   output logic reg_update,
   output logic illegal_trap
);
   ea_pkg::state_t state_q, state_d;
   logic [2:0] mode_q, mode_d, reg_q, reg_d;
   logic [1:0] size_q, size_d, left_q, left_d;
   logic [31:0] pc_q, pc_d, bd_q, bd_d;
   logic [15:0] fmt_q, fmt_d;
   logic ext_req_q, ext_req_d, done_q, done_d, trap_q, trap_d;
   logic [31:0] ea_q, ea_d, imm_q, imm_d;
   logic is_reg_q, is_reg_d, is_imm_q, is_imm_d, pspace_q, pspace_d, upd_q, upd_d;
   logic [3:0] rsel_q, rsel_d;
   logic [31:0] ctrl_q, ctrl_d, last_ea_q, last_ea_d, prdata_q, prdata_d;
   logic ill_q, ill_d, pready_q, pready_d, pslverr_q, pslverr_d;
   logic [2:0] words_q, words_d;
   logic indexed, full, pc_rel, bs, is_sup, idx_sup;
   logic [1:0] bdsz;
   logic [31:0] base_val, idx_raw, idx_val, disp_val, dec_val;
   logic [1:0] plain_words;
   logic start_ok, wr_en, rd_phase;

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the captured mode and extension word.

   assign indexed = (mode_q == `MODE_INDEX) ||
                    (mode_q == `MODE_SPECIAL && reg_q == `SUB_PC_INDEX);
   assign full = indexed && fmt_q[`EXT_FULL_BIT];
   assign pc_rel = (mode_q == `MODE_SPECIAL) &&
                   (reg_q == `SUB_PC_DISP || reg_q == `SUB_PC_INDEX);
   assign bs = fmt_q[`EXT_BS_BIT];
   assign is_sup = fmt_q[`EXT_IS_BIT];
   assign bdsz = fmt_q[`EXT_BDSZ_MSB:`EXT_BDSZ_LSB];
   assign idx_sup = !indexed || (full && is_sup);
   assign start_ok = start && ctrl_q[`CTRL_EN_BIT];

   // Extension words needed by modes that carry no index word.
   always_comb
   begin
      plain_words = 2'h0;
      if (ea_mode == `MODE_DISP16)
      begin
         plain_words = 2'h1;
      end
      else if (ea_mode == `MODE_SPECIAL)
      begin
         case (ea_reg)
            `SUB_ABS_SHORT: plain_words = 2'h1;
            `SUB_ABS_LONG: plain_words = 2'h2;
            `SUB_PC_DISP: plain_words = 2'h1;
            `SUB_IMMEDIATE: plain_words = (op_size == `SIZE_LONG) ? 2'h2 : 2'h1;
            default: plain_words = 2'h0;
         endcase
      end
   end

   always_comb
   begin
      dec_val = 32'h0000_0004;
      if (size_q == `SIZE_BYTE)
      begin
         dec_val = 32'h0000_0001;
      end
      else if (size_q == `SIZE_WORD)
      begin
         dec_val = 32'h0000_0002;
      end
   end

   // Base operand: address register, program counter or zero.
   always_comb
   begin
      base_val = 32'h0000_0000;
      if (mode_q == `MODE_IND || mode_q == `MODE_POSTINC || mode_q == `MODE_DISP16 ||
          mode_q == `MODE_INDEX)
      begin
         base_val = addr_regs[reg_q];
      end
      else if (mode_q == `MODE_PREDEC)
      begin
         base_val = addr_regs[reg_q] - dec_val;
      end
      else if (pc_rel)
      begin
         base_val = pc_q;
      end
      if (full && bs)
      begin
         base_val = 32'h0000_0000;
      end
   end

   // Displacement operand.
   always_comb
   begin
      disp_val = 32'h0000_0000;
      if (mode_q == `MODE_DISP16 || (mode_q == `MODE_SPECIAL &&
          (reg_q == `SUB_ABS_SHORT || reg_q == `SUB_PC_DISP)))
      begin
         disp_val = {{16{bd_q[15]}}, bd_q[15:0]};
      end
      else if (mode_q == `MODE_SPECIAL && reg_q == `SUB_ABS_LONG)
      begin
         disp_val = bd_q;
      end
      else if (indexed && !full)
      begin
         disp_val = {{24{fmt_q[7]}}, fmt_q[7:0]};
      end
      else if (full && bdsz == `BDSZ_WORD)
      begin
         disp_val = {{16{bd_q[15]}}, bd_q[15:0]};
      end
      else if (full && bdsz == `BDSZ_LONG)
      begin
         disp_val = bd_q;
      end
   end

   assign idx_raw = fmt_q[`EXT_DA_BIT] ? addr_regs[fmt_q[`EXT_REG_MSB:`EXT_REG_LSB]] :
                    data_regs[fmt_q[`EXT_REG_MSB:`EXT_REG_LSB]];

   index_scaler u_index_scaler
   (
      .index_raw(idx_raw),
      .long_sel(fmt_q[`EXT_WL_BIT]),
      .scale(fmt_q[`EXT_SCALE_MSB:`EXT_SCALE_LSB]),
      .suppress(idx_sup),
      .index_out(idx_val)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: extension word fetch and address completion.

   always_comb
   begin
      state_d = state_q;
      mode_d = mode_q;
      reg_d = reg_q;
      size_d = size_q;
      pc_d = pc_q;
      bd_d = bd_q;
      fmt_d = fmt_q;
      left_d = left_q;
      ext_req_d = ext_req_q;
      words_d = words_q;
      done_d = 1'b0;
      trap_d = 1'b0;
      ea_d = ea_q;
      imm_d = imm_q;
      is_reg_d = is_reg_q;
      is_imm_d = is_imm_q;
      pspace_d = pspace_q;
      upd_d = upd_q;
      rsel_d = rsel_q;
      case (state_q)
         ea_pkg::ST_IDLE:
         begin
            if (start_ok)
            begin
               mode_d = ea_mode;
               reg_d = ea_reg;
               size_d = op_size;
               pc_d = ext_pc;
               bd_d = 32'h0000_0000;
               fmt_d = 16'h0000;
               words_d = 3'h0;
               if (ea_mode == `MODE_SPECIAL && ea_reg > `SUB_IMMEDIATE)
               begin
                  trap_d = 1'b1;
               end
               else if (ea_mode == `MODE_INDEX ||
                        (ea_mode == `MODE_SPECIAL && ea_reg == `SUB_PC_INDEX))
               begin
                  state_d = ea_pkg::ST_FIRST;
                  ext_req_d = 1'b1;
               end
               else if (plain_words != 2'h0)
               begin
                  left_d = plain_words;
                  state_d = ea_pkg::ST_BD;
                  ext_req_d = 1'b1;
               end
               else
               begin
                  state_d = ea_pkg::ST_CALC;
               end
            end
         end
         ea_pkg::ST_FIRST:
         begin
            if (ext_valid)
            begin
               fmt_d = ext_word;
               words_d = words_q + 3'h1;
               ext_req_d = 1'b0;
               state_d = ea_pkg::ST_CALC;
               if (ext_word[`EXT_FULL_BIT])
               begin
                  if (ext_word[`EXT_IIS_MSB:`EXT_IIS_LSB] != `IIS_NONE ||
                      ext_word[`EXT_BDSZ_MSB:`EXT_BDSZ_LSB] == `BDSZ_RESERVED)
                  begin
                     trap_d = 1'b1;
                     state_d = ea_pkg::ST_IDLE;
                  end
                  else if (ext_word[`EXT_BDSZ_MSB:`EXT_BDSZ_LSB] != `BDSZ_NULL)
                  begin
                     left_d = ext_word[`EXT_BDSZ_MSB:`EXT_BDSZ_LSB] - 2'h1;
                     ext_req_d = 1'b1;
                     state_d = ea_pkg::ST_BD;
                  end
               end
            end
         end
         ea_pkg::ST_BD:
         begin
            if (ext_valid)
            begin
               // High word arrives first, so the long displacement shifts in.
               bd_d = {bd_q[15:0], ext_word};
               words_d = words_q + 3'h1;
               left_d = left_q - 2'h1;
               if (left_q == 2'h1)
               begin
                  ext_req_d = 1'b0;
                  state_d = ea_pkg::ST_CALC;
               end
            end
         end
         ea_pkg::ST_CALC:
         begin
            ea_d = base_val + idx_val + disp_val;
            is_reg_d = (mode_q == `MODE_DREG) || (mode_q == `MODE_AREG);
            rsel_d = {mode_q == `MODE_AREG, reg_q};
            upd_d = (mode_q == `MODE_POSTINC) || (mode_q == `MODE_PREDEC);
            is_imm_d = (mode_q == `MODE_SPECIAL) && (reg_q == `SUB_IMMEDIATE);
            pspace_d = pc_rel || is_imm_d;
            imm_d = 32'h0000_0000;
            if (is_imm_d)
            begin
               ea_d = pc_q;
               imm_d = (size_q == `SIZE_LONG) ? bd_q :
                       (size_q == `SIZE_WORD) ? {16'h0000, bd_q[15:0]} :
                       {24'h00_0000, bd_q[7:0]};
            end
            done_d = 1'b1;
            state_d = ea_pkg::ST_IDLE;
         end
         default:
         begin
            state_d = ea_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_q <= ea_pkg::ST_IDLE;
         mode_q <= 3'h0;
         reg_q <= 3'h0;
         size_q <= 2'h0;
         pc_q <= 32'h0000_0000;
         bd_q <= 32'h0000_0000;
         fmt_q <= 16'h0000;
         left_q <= 2'h0;
         ext_req_q <= 1'b0;
         words_q <= 3'h0;
         done_q <= 1'b0;
         trap_q <= 1'b0;
         ea_q <= 32'h0000_0000;
         imm_q <= 32'h0000_0000;
         is_reg_q <= 1'b0;
         is_imm_q <= 1'b0;
         pspace_q <= 1'b0;
         upd_q <= 1'b0;
         rsel_q <= 4'h0;
      end
      else
      begin
         state_q <= state_d;
         mode_q <= mode_d;
         reg_q <= reg_d;
         size_q <= size_d;
         pc_q <= pc_d;
         bd_q <= bd_d;
         fmt_q <= fmt_d;
         left_q <= left_d;
         ext_req_q <= ext_req_d;
         words_q <= words_d;
         done_q <= done_d;
         trap_q <= trap_d;
         ea_q <= ea_d;
         imm_q <= imm_d;
         is_reg_q <= is_reg_d;
         is_imm_q <= is_imm_d;
         pspace_q <= pspace_d;
         upd_q <= upd_d;
         rsel_q <= rsel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave with one wait state so that read data comes from a flop.

   assign rd_phase = psel && penable && !pready_q;
   assign wr_en = psel && penable && pready_q && pwrite;

   always_comb
   begin
      ctrl_d = ctrl_q;
      last_ea_d = done_d ? ea_d : last_ea_q;
      ill_d = ill_q;
      pready_d = rd_phase;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      if (rd_phase)
      begin
         prdata_d = 32'h0000_0000;
         if (paddr == `REG_CTRL)
         begin
            prdata_d = ctrl_q;
         end
         else if (paddr == `REG_STATUS)
         begin
            prdata_d = {30'h0, ill_q, state_q != ea_pkg::ST_IDLE};
         end
         else if (paddr == `REG_LAST_EA)
         begin
            prdata_d = last_ea_q;
         end
         else
         begin
            pslverr_d = 1'b1;
         end
      end
      if (wr_en && paddr == `REG_CTRL)
      begin
         ctrl_d = {31'h0, pwdata[`CTRL_EN_BIT]};
      end
      if (wr_en && paddr == `REG_STATUS && pwdata[`STAT_ILL_BIT])
      begin
         ill_d = 1'b0;
      end
      // A trap in the clearing cycle still sets the flag.
      if (trap_d)
      begin
         ill_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctrl_q <= `CTRL_RESET;
         last_ea_q <= 32'h0000_0000;
         ill_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         last_ea_q <= last_ea_d;
         ill_q <= ill_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign ext_req = ext_req_q;
   assign done = done_q;
   assign ea_addr = ea_q;
   assign ea_is_reg = is_reg_q;
   assign ea_is_imm = is_imm_q;
   assign imm_data = imm_q;
   assign ea_reg_sel = rsel_q;
   assign program_space = pspace_q;
   assign reg_update = upd_q;
   assign illegal_trap = trap_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence calc_then_done;
      (state_q == ea_pkg::ST_CALC) ##1 done_q;
   endsequence

   reg_direct_a: assert property ((state_q == ea_pkg::ST_IDLE && start_ok &&
      ea_mode == `MODE_DREG) |-> ##1 calc_then_done ##0 (is_reg_q &&
      rsel_q == {1'b0, $past(ea_reg, 2)})) else $error("register direct map wrong");
   bad_submode_a: assert property ((state_q == ea_pkg::ST_IDLE && start_ok &&
      ea_mode == `MODE_SPECIAL && ea_reg > `SUB_IMMEDIATE) |=> (trap_q && !done_q))
      else $error("bad submode not trapped");
   brief_timing_a: assert property (
      (state_q == ea_pkg::ST_FIRST && ext_valid && !ext_word[`EXT_FULL_BIT]) |=>
      calc_then_done) else $error("brief form timing");
   indirect_trap_a: assert property ((state_q == ea_pkg::ST_FIRST && ext_valid &&
      ext_word[`EXT_FULL_BIT] && ext_word[`EXT_IIS_MSB:`EXT_IIS_LSB] != `IIS_NONE)
      |=> (trap_q && state_q == ea_pkg::ST_IDLE && ill_q)) else $error("no trap");
   base_sup_a: assert property ((state_q == ea_pkg::ST_CALC && full && bs &&
      is_sup && bdsz == `BDSZ_NULL) |=> (ea_q == 32'h0000_0000)) else $error("base not suppressed");
   index_sup_a: assert property ((state_q == ea_pkg::ST_CALC && full && is_sup) |=>
      (ea_q == $past(base_val) + $past(disp_val))) else $error("index not suppressed");
   ea_sum_a: assert property ((state_q == ea_pkg::ST_CALC && !is_imm_d) |=>
      (done_q && ea_q == $past(base_val) + $past(idx_val) + $past(disp_val)))
      else $error("address sum wrong");
   scale_a: assert property ((state_q == ea_pkg::ST_CALC && indexed &&
      !idx_sup && fmt_q[`EXT_WL_BIT]) |->
      (idx_val == (idx_raw << fmt_q[`EXT_SCALE_MSB:`EXT_SCALE_LSB])))
      else $error("index scale wrong");
   word_index_a: assert property ((state_q == ea_pkg::ST_CALC && indexed &&
      !idx_sup && !fmt_q[`EXT_WL_BIT] && fmt_q[`EXT_SCALE_MSB:`EXT_SCALE_LSB] == 2'h0) |->
      (idx_val == {{16{idx_raw[15]}}, idx_raw[15:0]})) else $error("word index wrong");
   long_words_a: assert property ((done_q && $past(full) &&
      $past(bdsz) == `BDSZ_LONG) |-> (words_q == 3'h3)) else $error("word count wrong");
   // A suppressed base drops the program counter from the sum as well.
   pc_space_a: assert property ((state_q == ea_pkg::ST_CALC && pc_rel) |=>
      (program_space && ea_q == ($past(full && bs) ? 32'h0000_0000 : $past(pc_q)) +
      $past(idx_val) + $past(disp_val))) else $error("pc relative wrong");
endmodule // effective_address_generator
`default_nettype wire

// ==== verilog/index_scaler.sv ====
// Index operand path: sizing, scaling and suppression of the index register.
// Assumes a purely combinational use inside the address adder's cycle.
`default_nettype none
module index_scaler
(
   input wire logic [31:0] index_raw,
   input wire logic long_sel,
   input wire logic [1:0] scale,
   input wire logic suppress,
   output logic [31:0] index_out
);
   logic [31:0] sized;

   // A word index is the low half sign-extended to a full long word.
   assign sized = long_sel ? index_raw : {{16{index_raw[15]}}, index_raw[15:0]};
   // Scaling is a plain shift in the same cycle, so it costs no extra time.
   assign index_out = suppress ? 32'h0000_0000 : (sized << scale);
endmodule // index_scaler
`default_nettype wire
